// ---- verilog/flash_host_pkg.sv ----
/*
  Shared constants and types of the parallel NOR flash host controller:
  register map, command codes, bus cycle timing, pin and request carriers.
  Assumes a 250 MHz system clock; all times are converted to cycles here.
*/
package flash_host_pkg;

  localparam int CLK_PS = 4000;
  localparam int ADDR_W = 22;
  localparam int DQ_W = 16;

  // bus timing, in ns as specified, converted to whole clock cycles
  localparam int SETUP_NS = 8;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 8;
  localparam int READ_ACC_NS = 100;
  localparam int GLITCH_NS = 5;
  localparam int POWERUP_NS = 1000;
  localparam int HW_RST_NS = 500;
  localparam int HW_RECOVER_NS = 1000;
  localparam int BUSY_SETTLE_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int READ_CYC = (READ_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int POWERUP_CYC = (POWERUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HW_RST_CYC = (HW_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HW_RECOVER_CYC = (HW_RECOVER_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  // control and status fields
  localparam int CTRL_BYTE_MODE = 0;
  localparam int CTRL_SEC_LOCKED = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_READY = 3;
  localparam int ST_AUTOSEL = 4;
  localparam int ST_SECURE = 5;
  localparam int ST_REFUSED = 6;
  localparam int ST_LIMIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // flash command data and unlock addresses (word / byte mode)
  localparam logic [7:0] FC_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FC_UNLOCK2 = 8'h55;
  localparam logic [7:0] FC_RESET = 8'hF0;
  localparam logic [7:0] FC_AUTOSEL = 8'h90;
  localparam logic [7:0] FC_PROGRAM = 8'hA0;
  localparam logic [7:0] FC_SEC_ENTER = 8'h88;
  localparam logic [7:0] FC_SEC_EXIT4 = 8'h00;
  localparam logic [11:0] UNLOCK_A1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK_A2_WORD = 12'h2AA;
  localparam logic [11:0] UNLOCK_A1_BYTE = 12'hAAA;
  localparam logic [11:0] UNLOCK_A2_BYTE = 12'h555;
  localparam int LIMIT_BIT = 5;
  localparam int POLL_BIT = 7;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_WRITE = 4'h2,
    OP_RESET = 4'h3,
    OP_AUTOSEL = 4'h4,
    OP_PROGRAM = 4'h5,
    OP_SEC_ENTER = 4'h6,
    OP_SEC_EXIT = 4'h7,
    OP_HW_RESET = 4'h8
  } op_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
  } cyc_req_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_o;
    logic [DQ_W-1:0] dq_oe;
  } bus_pins_t;

endpackage

// ---- verilog/flash_bus_cycle.sv ----
/*
  One asynchronous flash bus cycle, write or read, timed in clock cycles.
  Assumes dq_i is stable and synchronous to aclk while output enable is low.
*/
`timescale 1ns/10ps
module flash_bus_cycle (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic start,
  input flash_host_pkg::cyc_req_t req,
  output logic done,
  output logic [flash_host_pkg::DQ_W-1:0] rdata,
  // pins
  input wire logic [flash_host_pkg::DQ_W-1:0] dq_i,
  output flash_host_pkg::bus_pins_t pins
);

  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ} cyc_state_t;
  cyc_state_t state;
  logic [7:0] count;
  logic is_write;
  wire count_end = (count == 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= C_IDLE;
      count <= 8'h00;
      done <= 1'b0;
      rdata <= '0;
      is_write <= 1'b0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: '0};
    end else begin
      done <= 1'b0;
      if (count != 8'h00) count <= count - 8'h01;
      case (state)
        C_IDLE: if (start) begin
          // oe held high before ce falls so no write is inhibited or misread
          is_write <= req.write;
          pins.addr <= req.addr;
          pins.dq_o <= req.data;
          pins.dq_oe <= {flash_host_pkg::DQ_W{req.write}};
          pins.ce_n <= 1'b0;
          pins.oe_n <= 1'b1;
          count <= 8'(flash_host_pkg::SETUP_CYC);
          state <= C_SETUP;
        end
        C_SETUP: if (count_end) begin
          // address is taken at this later falling edge of we  [RL9]
          if (is_write) begin
            pins.we_n <= 1'b0;
            count <= 8'(flash_host_pkg::STROBE_CYC);
            state <= C_STROBE;
          end else begin
            pins.oe_n <= 1'b0;
            count <= 8'(flash_host_pkg::READ_CYC);
            state <= C_READ;
          end
        end
        C_STROBE: if (count_end) begin
          // we rises first, before ce, so data is taken here  [RL9]
          pins.we_n <= 1'b1;
          count <= 8'(flash_host_pkg::HOLD_CYC);
          state <= C_HOLD;
        end
        C_READ: if (count_end) begin
          rdata <= dq_i;
          pins.oe_n <= 1'b1;
          count <= 8'(flash_host_pkg::HOLD_CYC);
          state <= C_HOLD;
        end
        C_HOLD: if (count_end) begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= '0;
          done <= 1'b1;
          state <= C_IDLE;
        end
        default: state <= C_IDLE;
      endcase
    end
  end

  // the write strobe is never shorter than the glitch filter of the flash;
  // a counter saturating at 255 keeps the check cheap for strobes of up to 255 cycles
  logic [7:0] we_low_count;
  always_ff @(posedge aclk) begin
    if (!aresetn) we_low_count <= 8'h00;
    else if (pins.we_n) we_low_count <= 8'h00;
    else if (we_low_count != 8'hFF) we_low_count <= we_low_count + 8'h01;
  end
  sequence we_rise_s;
    $rose(pins.we_n);
  endsequence
  strobe_width_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    we_rise_s |-> we_low_count >= 8'(flash_host_pkg::STROBE_CYC))
    else $error("write strobe shorter than required");
  write_qualify_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    !pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("write strobe low without select or with output enable");
  data_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    $rose(pins.we_n) |-> !pins.ce_n && pins.dq_oe != '0)
    else $error("data released before the write strobe rose");

endmodule // flash_bus_cycle

// ---- verilog/flash_host_ctrl.sv ----
/*
  Host controller for an asynchronous parallel NOR flash: software orders
  command sequences over AXI4-Lite, the block runs them on the flash pins,
  waits on ready/busy, verifies programmed data and reports status.
  Assumes flash inputs are synchronous to aclk; the flash is powered with
  this block, so a power-up quiet time runs after every reset.
  // Notes on behaviour
  // [RL1] security sector is never erased, only programmed
  // [RL2] security programming uses only the standard sequence
  // [RL3] security protect is run by software afterwards
  // [RL4] programming a locked security sector is refused
  // [RL5] write strobe is far longer than glitch width
  // [RL6] write strobe low only with select low, oe high
  // [RL7] no writes during the power-up quiet time
  // [RL8] malformed sequences return the flash to reading
  // [RL9] address at later fall, data first rise
  // [RL10] erase suspend read is the flash's own concern
  // [RL11] reset command follows limit-exceeded or leaves autoselect
  // [RL12] erase cancelling by reset lies with the flash
  // [RL13] reset returns an unfinished program to reading
  // [RL14] reset is also legal between autoselect cycles
  // [RL15] autoselect only issued while flash is ready
  // [RL16] autoselect entry: two unlocks, then bank command
  // [RL17] id reads use plain reads at bank offsets
  // [RL18] security entry three cycles, exit four cycles
  // [RL19] program: two unlocks, setup, address with data
  // [RL20] completion waited on ready/busy and data poll
  // [RL21] no command written while the flash is busy
  // [RL22] read-back mismatch flags a failed program
*/
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module flash_host_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output flash_host_pkg::bus_pins_t flash_bus,
  input wire logic [flash_host_pkg::DQ_W-1:0] flash_dq_i,
  output logic flash_reset_n,
  output logic flash_byte_n,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {S_POWERUP, S_IDLE, S_ISSUE, S_WAIT, S_SETTLE, S_POLL, S_HWRST} state_t;
  state_t state;

  logic [1:0] ctrl;
  logic [flash_host_pkg::ADDR_W-1:0] addr;
  logic [flash_host_pkg::DQ_W-1:0] wdata;
  logic [flash_host_pkg::DQ_W-1:0] rdata;
  flash_host_pkg::op_t op;
  logic [1:0] step;
  logic [15:0] count;
  logic done;
  logic error;
  logic refused;
  logic limit;
  logic in_autosel;
  logic in_secure;
  logic cyc_start;
  logic cyc_verify;
  flash_host_pkg::cyc_req_t cyc_req;
  wire cyc_done;
  wire [flash_host_pkg::DQ_W-1:0] cyc_rdata;

  // register decode
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wr_ctrl = wr_take && s_axi_awaddr == flash_host_pkg::REG_CTRL;
  wire wr_addr = wr_take && s_axi_awaddr == flash_host_pkg::REG_ADDR;
  wire wr_data = wr_take && s_axi_awaddr == flash_host_pkg::REG_DATA;
  wire wr_cmd = wr_take && s_axi_awaddr == flash_host_pkg::REG_CMD;
  wire wr_hit = wr_ctrl || wr_addr || wr_data || wr_cmd;
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;
  wire idle = (state == S_IDLE);
  wire busy = !idle;
  wire [7:0] status = {limit, refused, in_secure, in_autosel, ready_busy_n, error, done, busy};
  wire rd_ctrl = s_axi_araddr == flash_host_pkg::REG_CTRL;
  wire rd_addr = s_axi_araddr == flash_host_pkg::REG_ADDR;
  wire rd_data = s_axi_araddr == flash_host_pkg::REG_DATA;
  wire rd_cmd = s_axi_araddr == flash_host_pkg::REG_CMD;
  wire rd_status = s_axi_araddr == flash_host_pkg::REG_STATUS;
  wire rd_rdata = s_axi_araddr == flash_host_pkg::REG_RDATA;
  wire rd_hit = rd_ctrl || rd_addr || rd_data || rd_cmd || rd_status || rd_rdata;
  wire [31:0] rd_value = rd_ctrl ? {30'h0, ctrl} :
                         rd_addr ? {10'h0, addr} :
                         rd_data ? {16'h0, wdata} :
                         rd_cmd ? {28'h0, op} :
                         rd_status ? {24'h0, status} :
                         rd_rdata ? {16'h0, rdata} : 32'h0;

  // command acceptance
  wire [3:0] cmd_code = s_axi_wdata[3:0];
  wire byte_mode = ctrl[flash_host_pkg::CTRL_BYTE_MODE];
  wire cmd_valid = cmd_code >= 4'h1 && cmd_code <= 4'h8; // RL1 RL2 RL10 RL12
  wire sec_locked_prog = cmd_code == flash_host_pkg::OP_PROGRAM && in_secure
                         && ctrl[flash_host_pkg::CTRL_SEC_LOCKED]; // RL4
  wire needs_ready = cmd_code != flash_host_pkg::OP_HW_RESET;
  wire cmd_refuse = !idle || !cmd_valid || sec_locked_prog || (needs_ready && !ready_busy_n); // RL15 RL21
  wire cmd_go = wr_cmd && !cmd_refuse;

  // sequence tables
  wire [11:0] ua1 = byte_mode ? flash_host_pkg::UNLOCK_A1_BYTE : flash_host_pkg::UNLOCK_A1_WORD;
  wire [11:0] ua2 = byte_mode ? flash_host_pkg::UNLOCK_A2_BYTE : flash_host_pkg::UNLOCK_A2_WORD;
  wire [flash_host_pkg::ADDR_W-1:0] bank_ua1 = {addr[flash_host_pkg::ADDR_W-1:12], ua1};
  wire [flash_host_pkg::ADDR_W-1:0] bank_ua2 = {addr[flash_host_pkg::ADDR_W-1:12], ua2};
  wire single_op = op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_WRITE
                   || op == flash_host_pkg::OP_RESET;
  wire [1:0] last_step = single_op ? 2'h0 :
                         (op == flash_host_pkg::OP_AUTOSEL || op == flash_host_pkg::OP_SEC_ENTER) ? 2'h2 : 2'h3;
  wire [7:0] third_code = op == flash_host_pkg::OP_AUTOSEL ? flash_host_pkg::FC_AUTOSEL : // RL16
                          op == flash_host_pkg::OP_PROGRAM ? flash_host_pkg::FC_PROGRAM : // RL19
                          op == flash_host_pkg::OP_SEC_ENTER ? flash_host_pkg::FC_SEC_ENTER : // RL18
                          flash_host_pkg::FC_AUTOSEL;
  wire [7:0] fourth_code = op == flash_host_pkg::OP_SEC_EXIT ? flash_host_pkg::FC_SEC_EXIT4 : wdata[7:0];
  wire [flash_host_pkg::ADDR_W-1:0] fourth_addr = op == flash_host_pkg::OP_SEC_EXIT ? bank_ua1 : addr;

  always_comb begin
    cyc_req = '{write: 1'b1, addr: addr, data: wdata};
    if (cyc_verify) begin
      cyc_req.write = 1'b0;
    end else if (single_op) begin
      cyc_req.write = op != flash_host_pkg::OP_READ; // RL17
      // the reset command ignores the address, so the user address is sent as is
      if (op == flash_host_pkg::OP_RESET) cyc_req.data = {8'h00, flash_host_pkg::FC_RESET}; // RL11 RL13 RL14
    end else begin
      case (step) // RL8
        2'h0: cyc_req = '{write: 1'b1, addr: bank_ua1, data: {8'h00, flash_host_pkg::FC_UNLOCK1}};
        2'h1: cyc_req = '{write: 1'b1, addr: bank_ua2, data: {8'h00, flash_host_pkg::FC_UNLOCK2}};
        2'h2: cyc_req = '{write: 1'b1, addr: bank_ua1, data: {8'h00, third_code}};
        2'h3: cyc_req = '{write: 1'b1, addr: fourth_addr,
                          data: op == flash_host_pkg::OP_PROGRAM ? wdata : {8'h00, fourth_code}};
        default: cyc_req = '{write: 1'b1, addr: addr, data: wdata};
      endcase
    end
  end

  // poll verdict: data-poll bit and whole data matching means done; otherwise a poll match or the limit bit means failure
  wire poll_match = cyc_rdata[flash_host_pkg::POLL_BIT] == wdata[flash_host_pkg::POLL_BIT];
  wire poll_limit = cyc_rdata[flash_host_pkg::LIMIT_BIT];
  wire byte_ok = cyc_rdata[7:0] == wdata[7:0];
  wire word_ok = byte_mode ? byte_ok : cyc_rdata == wdata;
  wire count_zero = (count == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flash_host_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= flash_host_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= wr_take;
      s_axi_wready <= wr_take;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? flash_host_pkg::RESP_OKAY : flash_host_pkg::RESP_DECERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      s_axi_arready <= rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_hit ? flash_host_pkg::RESP_OKAY : flash_host_pkg::RESP_DECERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 2'h0;
      addr <= '0;
      wdata <= '0;
    end else begin
      if (wr_ctrl && s_axi_wstrb[0]) ctrl <= s_axi_wdata[1:0];
      if (wr_addr && idle) addr <= s_axi_wdata[flash_host_pkg::ADDR_W-1:0];
      if (wr_data && idle) wdata <= s_axi_wdata[flash_host_pkg::DQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_POWERUP;
      count <= 16'(flash_host_pkg::POWERUP_CYC);
      op <= flash_host_pkg::OP_NONE;
      step <= 2'h0;
      done <= 1'b0;
      error <= 1'b0;
      refused <= 1'b0;
      limit <= 1'b0;
      rdata <= '0;
      in_autosel <= 1'b0;
      in_secure <= 1'b0;
      cyc_start <= 1'b0;
      cyc_verify <= 1'b0;
      flash_reset_n <= 1'b0;
      flash_byte_n <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      flash_byte_n <= !byte_mode;
      if (!count_zero) count <= count - 16'h0001;
      if (wr_cmd && cmd_refuse) refused <= 1'b1;
      else if (cmd_go) refused <= 1'b0;
      case (state)
        S_POWERUP: begin
          // reset is released at once, then the flash sits in read mode through the quiet time  [RL7]
          flash_reset_n <= 1'b1;
          if (count_zero) state <= S_IDLE;
        end
        S_IDLE: if (cmd_go) begin
          op <= flash_host_pkg::op_t'(cmd_code);
          step <= 2'h0;
          done <= 1'b0;
          error <= 1'b0;
          limit <= 1'b0;
          cyc_verify <= 1'b0;
          if (cmd_code == flash_host_pkg::OP_HW_RESET) begin
            flash_reset_n <= 1'b0;
            count <= 16'(flash_host_pkg::HW_RST_CYC);
            state <= S_HWRST;
          end else state <= S_ISSUE;
        end
        S_ISSUE: begin
          cyc_start <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: if (cyc_done) begin
          if (cyc_verify) begin
            rdata <= cyc_rdata;
            if (poll_match || poll_limit) begin
              // the same read that matched the poll bit must also match the whole data
              if (poll_match && word_ok) begin
                done <= 1'b1;
                state <= S_IDLE;
              end else begin
                // failed program, limit bit, or a 0 that cannot become 1  [RL22]
                error <= 1'b1;
                limit <= poll_limit;
                op <= flash_host_pkg::OP_RESET; // RL11
                cyc_verify <= 1'b0;
                step <= 2'h0;
                state <= S_ISSUE;
              end
            end else state <= S_ISSUE;
          end else if (step != last_step) begin
            step <= step + 2'h1;
            state <= S_ISSUE;
          end else begin
            if (op == flash_host_pkg::OP_READ) rdata <= cyc_rdata;
            if (op == flash_host_pkg::OP_AUTOSEL) in_autosel <= 1'b1;
            if (op == flash_host_pkg::OP_RESET) in_autosel <= 1'b0;
            if (op == flash_host_pkg::OP_SEC_ENTER) in_secure <= 1'b1; // RL18
            if (op == flash_host_pkg::OP_SEC_EXIT) in_secure <= 1'b0; // RL18
            if (op == flash_host_pkg::OP_PROGRAM) begin
              count <= 16'(flash_host_pkg::BUSY_SETTLE_CYC);
              state <= S_SETTLE;
            end else begin
              done <= op != flash_host_pkg::OP_RESET || !error;
              state <= S_IDLE;
            end
          end
        end
        S_SETTLE: if (count_zero) state <= S_POLL;
        // nothing is written until the embedded program reports ready  [RL20] [RL21]
        S_POLL: if (ready_busy_n) begin
          cyc_verify <= 1'b1;
          state <= S_ISSUE;
        end
        S_HWRST: begin
          if (count_zero && !flash_reset_n) begin
            flash_reset_n <= 1'b1;
            count <= 16'(flash_host_pkg::HW_RECOVER_CYC);
          end else if (count_zero) begin
            // the flash leaves the security region and autoselect on reset
            in_autosel <= 1'b0;
            in_secure <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cyc_start),
    .req(cyc_req),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .dq_i(flash_dq_i),
    .pins(flash_bus)
  );

  powerup_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    state == S_POWERUP |-> flash_bus.we_n && flash_bus.ce_n)
    else $error("flash strobed during power-up quiet time");
  busy_no_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL21
    state == S_POLL && !ready_busy_n |=> !cyc_start)
    else $error("cycle started while the flash is busy");
  limit_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    state == S_WAIT && cyc_done && cyc_verify && poll_limit && !word_ok
    |=> op == flash_host_pkg::OP_RESET && state == S_ISSUE)
    else $error("limit bit not followed by a reset command");
  locked_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    idle && wr_cmd && sec_locked_prog |=> refused && idle)
    else $error("program into locked security sector not refused");
  autosel_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
    idle && wr_cmd && cmd_code == flash_host_pkg::OP_AUTOSEL && !ready_busy_n |=> idle)
    else $error("autoselect issued while flash busy");
  sequence prog_setup_s;
    state == S_WAIT && op == flash_host_pkg::OP_PROGRAM && step == 2'h3 && cyc_done && !cyc_verify;
  endsequence
  prog_settle_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL19
    prog_setup_s |=> state == S_SETTLE ##25 state == S_SETTLE ##1 state == S_POLL)
    else $error("program data cycle not followed by busy settle");
  step_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    cyc_start && !cyc_verify && !single_op && step == 2'h2 |-> cyc_req.data[7:0] == third_code)
    else $error("third cycle carries a wrong command");

endmodule // flash_host_ctrl

// ---- testbench/flash_dev_model.sv ----
/*
  Behavioural parallel NOR flash: unlock decoding, program, autoselect, security region.
  Assumes pins synchronous to aclk and no pull on the data lines.
*/
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_ID = 16'h00C3 // arbitrary value
) (
  // clock and pins
  input wire logic aclk,
  input flash_host_pkg::bus_pins_t bus,
  input wire logic reset_n,
  input wire logic byte_n,
  // answers
  output logic [15:0] dq,
  output logic ready_busy_n
);
  logic [15:0] mem [32];
  logic [15:0] pd, last;
  logic we_q, asel, sec, arm, fail;
  logic [1:0] step;
  logic [5:0] busy, wlo;
  wire [11:0] a = bus.addr[11:0];
  wire [7:0] d = bus.dq_o[7:0];
  wire [4:0] ix = {sec, bus.addr[3:0]};
  wire [11:0] ua1 = byte_n ? 12'h555 : 12'hAAA;
  wire [11:0] ua2 = byte_n ? 12'h2AA : 12'h555;
  wire wr_end = bus.we_n && !we_q && !bus.ce_n && bus.oe_n && wlo > 1;
  // released lines show the inverse of the last value, never a held copy
  assign dq = (bus.ce_n || bus.oe_n) ? ~last : (busy != 0 || fail) ? {8'h00, ~pd[7], 1'b0, fail, 5'h00}
            : asel ? (a[7:0] == 8'h00 ? MAKER_ID : 16'h0000) : mem[ix];
  assign ready_busy_n = busy == 0;
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'hFFFF;
    last = 16'h0000;
    wlo = 6'h00;
  end
  always @(posedge aclk) begin
    we_q <= bus.we_n;
    last <= dq;
    wlo <= bus.we_n ? 6'h00 : wlo + 6'h01;
    if (!reset_n) begin
      {step, asel, sec, arm, fail, busy} <= '0;
    end else if (busy != 0) begin
      busy <= busy - 6'h01;
    end else if (wr_end) begin
      step <= 2'h0;
      arm <= 1'b0;
      if (arm) begin
        mem[ix] <= mem[ix] & bus.dq_o;
        pd <= bus.dq_o;
        fail <= |(bus.dq_o & ~mem[ix]);
        busy <= 6'h28;
      end else if (d == 8'hF0) {asel, fail} <= 2'h0;
      else if (step == 2'h3 && d == 8'h00) sec <= 1'b0;
      else if (step == 2'h0 && a == ua1 && d == 8'hAA) step <= 2'h1;
      else if (step == 2'h1 && a == ua2 && d == 8'h55) step <= 2'h2;
      else if (step == 2'h2 && d == 8'h90) {step, asel} <= sec ? 3'h6 : 3'h1;
      else if (step == 2'h2 && d == 8'hA0) arm <= 1'b1;
      else if (step == 2'h2 && d == 8'h88) sec <= 1'b1;
    end
  end
endmodule // flash_dev_model

// ---- testbench/flash_host_ctrl_tb.sv ----
/*
  Bench of the flash host controller: AXI4-Lite tasks run command sequences on a model flash.
  Assumes the model flash of this folder.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module flash_host_ctrl_tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, st;
  logic awready, wready, bvalid, arready, rvalid, rst_n, byte_n, rbn;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] dq;
  flash_host_pkg::bus_pins_t fbus;
  int err_count = 0, comparisons = 0;
  initial forever #2 aclk = ~aclk;
  flash_host_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .flash_bus(fbus), .flash_dq_i(dq), .flash_reset_n(rst_n), .flash_byte_n(byte_n), .ready_busy_n(rbn));
  flash_dev_model FLASH (.aclk(aclk), .bus(fbus), .reset_n(rst_n), .byte_n(byte_n), .dq(dq), .ready_busy_n(rbn));
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 3000) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 3000);
    guard(n);
    `CHK("bresp", er, bresp)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 3000);
    guard(n);
    st = rdata;
    rr = rresp;
    @(posedge aclk);
  endtask
  // issue a command and poll status until the controller is idle again
  task automatic op(input logic [3:0] c);
    int n = 0;
    wr(flash_host_pkg::REG_CMD, {28'h0, c}, 2'h0);
    do begin
      rd(flash_host_pkg::REG_STATUS);
      n++;
    end while (st[0] !== 1'b0 && n < 3000);
    guard(n);
  endtask
  task automatic setop(input logic [21:0] a, input logic [15:0] d, input logic [3:0] c);
    wr(flash_host_pkg::REG_ADDR, {10'h0, a}, 2'h0);
    wr(flash_host_pkg::REG_DATA, {16'h0, d}, 2'h0);
    op(c);
  endtask
  task automatic rdback(input logic [21:0] a, input logic [15:0] e);
    setop(a, 16'h0000, 4'h1);
    rd(flash_host_pkg::REG_RDATA);
    `CHK("array data", e, st[15:0])
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(flash_host_pkg::REG_STATUS);
    `CHK("busy", 1'b1, st[0])
    op(4'h1);
    `CHK("refused", 1'b1, st[6])
    wr(8'h3C, 32'h0, 2'h3);
    $display("test power-up done");
    setop(3, 16'h5A3C, 4'h5);
    `CHK("done", 1'b1, st[1])
    rdback(3, 16'h5A3C);
    setop(3, 16'hFFFF, 4'h5);
    `CHK("error", 1'b1, st[2])
    `CHK("limit", 1'b1, st[7])
    rdback(3, 16'h5A3C);
    $display("test program done");
    setop(0, 16'h0000, 4'h4);
    `CHK("autoselect", 1'b1, st[4])
    rdback(0, FLASH.MAKER_ID);
    op(4'h3);
    `CHK("autoselect", 1'b0, st[4])
    rdback(3, 16'h5A3C);
    $display("test autoselect done");
    op(4'h6);
    `CHK("secure", 1'b1, st[5])
    setop(2, 16'h1234, 4'h5);
    rdback(2, 16'h1234);
    op(4'h7);
    `CHK("secure", 1'b0, st[5])
    rdback(2, 16'hFFFF);
    wr(flash_host_pkg::REG_CTRL, 32'h2, 2'h0);
    op(4'h6);
    setop(2, 16'h0000, 4'h5);
    `CHK("refused", 1'b1, st[6])
    op(4'h8);
    `CHK("secure", 1'b0, st[5])
    $display("test security done");
    wr(flash_host_pkg::REG_CTRL, 32'h1, 2'h0);
    setop(4, 16'h00A5, 4'h5);
    `CHK("done", 1'b1, st[1])
    `CHK("byte_n", 1'b0, byte_n)
    rdback(4, 16'h00A5);
    $display("test byte mode done");
    finish_test();
  end
endmodule // flash_host_ctrl_tb
